// >>> rtl/ptt_timer.v
/*
  Periodic tick timer: a 24-bit down counter with reload, counter enable,
  interrupt enable and a pending tick that waits for handler entry.
  Period readback and current value are read straight from registers.
  Assumes every control input comes from logic on i_clock, so none of them
  is synchronised; only i_nrst is asynchronous, and its release passes two flops here
  before the rest of the block sees it.
  Assumes software keeps the period legal; a period of 0 is not refused but
  folded onto the longest period.
*/
`timescale 1ns/1ps
`include "ptt_defs.vh"
module ptt_timer (
  input  wire                     i_clock,
  input  wire                     i_nrst,
  input  wire                     i_enable,
  input  wire                     i_int_enable,
  input  wire                     i_period_wr,
  input  wire [`PTT_PERIOD_W-1:0] i_tick_period_value,
  input  wire                     i_current_wr,
  input  wire                     i_handler_entry,
  output wire [`PTT_PERIOD_W-1:0] o_tick_period_value,
  output wire [`PTT_CNT_W-1:0]    o_tick_current_value,
  output wire                     o_running,
  output wire                     o_rollover,
  output wire                     o_tick_irq
);
  localparam [0:0] ST_IDLE = 1'b0;
  localparam [0:0] ST_RUN  = 1'b1;

  reg                     rst_meta_n_reg;
  reg                     rst_n_reg;
  reg [`PTT_CNT_W-1:0]    reload_reg;
  reg [`PTT_CNT_W-1:0]    reload_next;
  reg [`PTT_PERIOD_W-1:0] period_reg;
  reg [`PTT_PERIOD_W-1:0] period_next;
  reg [`PTT_CNT_W-1:0]    tick_current_value_reg;
  reg [`PTT_CNT_W-1:0]    count_next;
  reg                     state_reg;
  reg                     state_next;
  reg                     roll_reg;
  reg                     roll_next;
  wire                    cnt_zero;
  wire                    irq_set;
  wire                    pend;

  // True when a counter value has reached the end of its period
  function is_zero;
    input [`PTT_CNT_W-1:0] value;
    begin
      is_zero = (value == `PTT_CNT_RST);
    end
  endfunction

  // Period 0 is outside the legal range; it reads back as the longest period
  function [`PTT_PERIOD_W-1:0] period_norm;
    input [`PTT_PERIOD_W-1:0] value;
    begin
      if (is_zero(value[`PTT_CNT_W-1:0]))
        period_norm = `PTT_PERIOD_MAX;
      else
        period_norm = {1'b0, value[`PTT_CNT_W-1:0]};
    end
  endfunction

  // Assertion stays asynchronous so the block resets with no clock running
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_meta_n_reg <= 1'b0;
      rst_n_reg      <= 1'b0;
    end else begin
      rst_meta_n_reg <= 1'b1;
      rst_n_reg      <= rst_meta_n_reg;
    end
  end

  // Only a period write moves these; the running count is left alone
  always @* begin
    reload_next = reload_reg;
    period_next = period_reg;
    if (i_period_wr) begin
      reload_next = i_tick_period_value[`PTT_CNT_W-1:0] - `PTT_ONE_CNT;
      period_next = period_norm(i_tick_period_value);
    end
  end

  // Enable is seen one clock late, so counting starts after o_running rises
  always @* begin
    case (state_reg)
      ST_IDLE: state_next = i_enable ? ST_RUN : ST_IDLE;
      ST_RUN:  state_next = i_enable ? ST_RUN : ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  assign cnt_zero = is_zero(tick_current_value_reg);

  always @* begin
    count_next = tick_current_value_reg;
    roll_next  = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        // Stopped: hold the count so a later enable resumes from it
        count_next = tick_current_value_reg;
      end
      ST_RUN: begin
        if (cnt_zero) begin
          count_next = reload_reg;
          roll_next  = 1'b1;
        end else begin
          count_next = tick_current_value_reg - `PTT_ONE_CNT;
        end
      end
      default: begin
        count_next = `PTT_CNT_RST;
        roll_next  = 1'b0;
      end
    endcase
    // A write clears to zero so the next enabled clock reloads
    if (i_current_wr) begin
      count_next = `PTT_CNT_RST;
      roll_next  = 1'b0;
    end
  end

  always @(posedge i_clock or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      reload_reg <= `PTT_RELOAD_RST;
      period_reg <= `PTT_PERIOD_RST;
    end else begin
      reload_reg <= reload_next;
      period_reg <= period_next;
    end
  end

  always @(posedge i_clock or negedge rst_n_reg) begin
    if (!rst_n_reg)
      tick_current_value_reg <= `PTT_CNT_RST;
    else
      tick_current_value_reg <= count_next;
  end

  always @(posedge i_clock or negedge rst_n_reg) begin
    if (!rst_n_reg)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end

  always @(posedge i_clock or negedge rst_n_reg) begin
    if (!rst_n_reg)
      roll_reg <= 1'b0;
    else
      roll_reg <= roll_next;
  end

  // Rollovers are masked before they reach the pending flag
  assign irq_set = roll_reg & i_int_enable;

  ptt_pend u_pend (
    .i_clock (i_clock),
    .i_rst_n (rst_n_reg),
    .i_set   (irq_set),
    .i_clear (i_handler_entry),
    .o_pend  (pend)
  );

  assign o_tick_period_value  = period_reg;
  assign o_tick_current_value = tick_current_value_reg;
  assign o_running            = state_reg;
  assign o_rollover           = roll_reg;
  assign o_tick_irq           = pend & i_int_enable;
endmodule // ptt_timer

// >>> rtl/ptt_defs.vh
/*
  Constants for the periodic tick timer: widths, reset values, longest period and count step.
  Assumes inclusion by bare name from the timer design files.
*/
`ifndef PTT_DEFS_VH
`define PTT_DEFS_VH
`define PTT_CNT_W        24
`define PTT_PERIOD_W     25
`define PTT_CNT_RST      24'h000000
`define PTT_RELOAD_RST   24'h000000
`define PTT_PERIOD_RST   25'h0000001
`define PTT_PERIOD_MAX   25'h1000000
`define PTT_ONE_CNT      24'h000001
`endif

// >>> rtl/ptt_pend.v
/*
  Pending flag for the tick interrupt: set by a rollover, cleared on handler entry.
  Assumes synchronous inputs on i_clock and an already synchronised reset.
*/
`timescale 1ns/1ps
module ptt_pend (
  input  wire i_clock,
  input  wire i_rst_n,
  input  wire i_set,
  input  wire i_clear,
  output wire o_pend
);
  reg pend_reg;
  reg pend_next;

  always @* begin
    pend_next = pend_reg;
    if (i_clear)
      pend_next = 1'b0;
    // A rollover in the same cycle as handler entry must not be lost
    if (i_set)
      pend_next = 1'b1;
  end

  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n)
      pend_reg <= 1'b0;
    else
      pend_reg <= pend_next;
  end

  assign o_pend = pend_reg;
endmodule // ptt_pend

// >>> sim/ptt_props.sv
/* Checker for the tick timer ports.
   Assumes it is bound into ptt_timer. */
`timescale 1ns/1ps
module ptt_props (
  input wire        i_clock, i_nrst, i_int_enable, i_period_wr, i_current_wr,
  input wire        i_handler_entry, o_running, o_rollover, o_tick_irq,
  input wire [24:0] i_tick_period_value, o_tick_period_value,
  input wire [23:0] o_tick_current_value);
  wire [23:0] c = o_tick_current_value;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  sequence s_roll; o_rollover && i_int_enable ##1 i_int_enable; endsequence
  a_irq_gated: assert property (o_tick_irq |-> i_int_enable) else $error("irq");
  a_stop_hold: assert property (!o_running && !i_current_wr |=> $stable(c))
    else $error("hold");
  a_count_down: assert property (o_running && c != 0 && !i_current_wr
    |=> c == $past(c) - 24'h1) else $error("step");
  a_reload_roll: assert property (o_running && c == 0 && !i_current_wr
    |=> o_rollover && c == 24'($past(o_tick_period_value) - 25'h1)) else $error("reload");
  a_cur_clear: assert property (i_current_wr |=> c == 0 && !o_rollover) else $error("clr");
  a_period_rb: assert property (i_period_wr && i_tick_period_value != 0
    |=> o_tick_period_value == $past(i_tick_period_value)) else $error("period");
  a_irq_raise: assert property (s_roll |-> o_tick_irq) else $error("raise");
  a_handler_clr: assert property (i_handler_entry && !o_rollover |=> !o_tick_irq)
    else $error("entry");
endmodule // ptt_props
bind ptt_timer ptt_props u_props (
  .i_clock              (i_clock),
  .i_nrst               (i_nrst),
  .i_int_enable         (i_int_enable),
  .i_period_wr          (i_period_wr),
  .i_current_wr         (i_current_wr),
  .i_handler_entry      (i_handler_entry),
  .o_running            (o_running),
  .o_rollover           (o_rollover),
  .o_tick_irq           (o_tick_irq),
  .i_tick_period_value  (i_tick_period_value),
  .o_tick_period_value  (o_tick_period_value),
  .o_tick_current_value (o_tick_current_value)
);

// >>> sim/ptt_cpu_model.sv
/* Processor model: enters the tick handler i_lat cycles after irq.
   Assumes inputs from the bench clock domain. */
`timescale 1ns/1ps
module ptt_cpu_model (
  input  wire       i_clock, i_irq,
  input  wire [1:0] i_lat,
  output reg        o_entry = 1'b0);
  reg [1:0] n_reg = 2'h0;
  // Entry alone clears the source; no software clear is modelled
  always @(negedge i_clock) begin
    o_entry <= 1'b0;
    n_reg <= i_irq ? n_reg + 2'h1 : 2'h0;
    if (i_irq && !o_entry && n_reg >= i_lat) o_entry <= 1'b1;
  end
endmodule // ptt_cpu_model

// >>> sim/testbench.sv
/* Self-checking bench for the tick timer.
   Assumes ptt_timer, its checker and ptt_cpu_model. */
`timescale 1ns/1ps
module testbench;
  reg         clk = 0, nrst = 0, en = 0, ie = 0, pw = 0, cw = 0;
  reg  [1:0]  lat = 2'h0;
  reg  [24:0] pv = 25'h3;
  wire [24:0] po;
  wire [23:0] cv;
  wire        run, ro, irq, he;
  integer     bad_count = 0, n_compared = 0, cyc = 0, t, k;
  always #5 clk = ~clk;
  ptt_timer dut (.i_clock(clk), .i_nrst(nrst), .i_enable(en), .i_int_enable(ie),
    .i_period_wr(pw), .i_tick_period_value(pv), .i_current_wr(cw), .i_handler_entry(he),
    .o_tick_period_value(po), .o_tick_current_value(cv), .o_running(run),
    .o_rollover(ro), .o_tick_irq(irq));
  ptt_cpu_model cpu (.i_clock(clk), .i_irq(irq), .i_lat(lat), .o_entry(he));
  task test_done; begin
    $display("compared %0d bad %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  end endtask
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin bad_count = bad_count + 1; test_done; end
  end
  task chk(input [24:0] g, e); begin
    n_compared = n_compared + 1;
    if (g !== e) begin bad_count = bad_count + 1; $display("[ERR] %0t got %h", $time, g); end
  end endtask
  task cyc_n(input integer n); repeat (n) @(negedge clk); endtask
  task wr(input [24:0] v); begin pv = v; pw = 1; cyc_n(1); pw = 0; end endtask
  task wait_ro; begin
    k = 0; cyc_n(1);
    while (!ro && k < 40) begin k = k + 1; cyc_n(1); end
    chk(ro, 1);
  end endtask
  task t_walk; begin
    wr(25'h3); ie = 1; cw = 1; en = 1; cyc_n(1); cw = 0;
    chk(run, 1);
    wait_ro; t = cyc; wait_ro;
    chk(cyc - t, 3);
    cyc_n(1); chk(irq, 1);
    cyc_n(1); chk(irq, 0);
    $display("walk done");
  end endtask
  task t_mask; begin
    ie = 0; wait_ro; cyc_n(1); chk(irq, 0);
    ie = 1; lat = 2'h2; $display("mask done");
  end endtask
  task t_stop; begin
    en = 0; cyc_n(2); t = cv; cyc_n(3); chk(cv, t);
    en = 1; cyc_n(1); chk(cv, t);
    cyc_n(1); chk(cv, t == 0 ? 2 : t - 1);
    $display("stop done");
  end endtask
  task t_period; begin
    wr(25'h5); chk(po, 5);
    chk(cv < 3, 1);
    wait_ro; chk(cv, 4);
    wr(25'h1000000); chk(po, 25'h1000000);
    cw = 1; cyc_n(1); cw = 0; chk(cv, 0);
    cyc_n(1); chk(cv, 24'hffffff);
    $display("period done");
  end endtask
  initial begin
    cyc_n(8); nrst = 1; cyc_n(3);
    t_walk; t_mask; t_stop; t_period; test_done;
  end
endmodule // testbench
